/* File: logic/csis_top.v */
/*
  Charger status and input-select logic with an AXI4-Lite register slave.
  Assumes the analog front end presents comparator results as level pins
  and the host drives the disable and source-select pins at all times.
*/
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ns
`include "csis_regs.vh"
module csis_top #(
  parameter PULSE_CYC = `CSIS_PULSE_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire hw_disable_in,
  input wire source_select,
  input wire has_dpdm,
  input wire usb_start,
  input wire dpdm_short,
  input wire charge_active,
  input wire charge_done,
  input wire fault_in,
  input wire ts_fault_in,
  input wire thermistor_sense_at_gate_drive_supply,
  output wire hiz_mode,
  output reg [1:0] usb_limit,
  output wire lowest_usb_limit_mode,
  output wire adapter_limit_hold,
  output wire ts_monitor_en,
  output wire stat_o,
  output wire stat_oe,
  output wire int_o,
  output wire int_oe,
  output wire irq,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam PW = 15;
  // Held at 32 bits first so the cut to the counter width is deliberate
  localparam [31:0] PULSE_LAST_W = PULSE_CYC - 1;
  localparam [PW-1:0] PULSE_LAST = PULSE_LAST_W[PW-1:0];

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [9:0] pin_s;
  csis_sync #(.W(10)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({hw_disable_in, source_select, has_dpdm, usb_start, dpdm_short,
        charge_active, charge_done, fault_in, ts_fault_in,
        thermistor_sense_at_gate_drive_supply}),
    .q(pin_s)
  );
  wire dis_s = pin_s[9];
  wire psel_s = pin_s[8];
  wire dpdm_s = pin_s[7];
  wire start_s = pin_s[6];
  wire short_s = pin_s[5];
  wire chg_s = pin_s[4];
  wire done_s = pin_s[3];
  wire flt_s = pin_s[2];
  wire tsf_s = pin_s[1];
  wire tsoff_s = pin_s[0];

  reg [31:0] ctrl;
  reg [`CSIS_IRQ_W-1:0] irq_stat;
  reg [`CSIS_IRQ_W-1:0] irq_mask;
  reg start_d;
  reg flt_d;
  reg tsf_d;
  reg done_d;
  reg [PW-1:0] pulse_cnt;
  reg pulse_on;

  wire en_stat = ctrl[`CSIS_CTRL_EN_STAT];
  // Disable is a plain level; the host must never float it
  assign hiz_mode = dis_s;
  assign ts_monitor_en = ~tsoff_s;
  wire ts_fault = tsf_s & ts_monitor_en;
  // Adapter path limit is never touched by D+/D- or source-select
  assign adapter_limit_hold = 1'b1;
  assign lowest_usb_limit_mode = (usb_limit == `CSIS_LIM_100);

  // ----------------------------------------
  // USB input limit selection
  // ----------------------------------------
  wire start_rise = start_s & ~start_d;
  always @(posedge aclk)
  begin
    if (!aresetn)
      usb_limit <= `CSIS_LIM_100;
    else if (start_rise)
    begin
      if (dpdm_s)
        usb_limit <= short_s ? `CSIS_LIM_1500 : `CSIS_LIM_100;
      else if (!psel_s)
        usb_limit <= `CSIS_LIM_1500;
      else if (ctrl[`CSIS_CTRL_VARIANT_500])
        usb_limit <= `CSIS_LIM_500;
      else
        usb_limit <= `CSIS_LIM_100;
    end
  end

  // ----------------------------------------
  // Fault pulse timer
  // ----------------------------------------
  // A fault during a running pulse is absorbed; one pulse per fault edge
  wire flt_rise = (flt_s & ~flt_d) | (ts_fault & ~tsf_d);
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_d <= 1'b0;
      flt_d <= 1'b0;
      tsf_d <= 1'b0;
      done_d <= 1'b0;
      pulse_cnt <= {PW{1'b0}};
      pulse_on <= 1'b0;
    end
    else
    begin
      start_d <= start_s;
      flt_d <= flt_s;
      tsf_d <= ts_fault;
      done_d <= done_s;
      if (pulse_on)
      begin
        if (pulse_cnt == PULSE_LAST)
          pulse_on <= 1'b0;
        pulse_cnt <= pulse_cnt + 1'b1;
      end
      else if (flt_rise && en_stat)
      begin
        pulse_on <= 1'b1;
        pulse_cnt <= {PW{1'b0}};
      end
    end
  end

  // ----------------------------------------
  // Open-drain status outputs
  // ----------------------------------------
  wire show_chg = chg_s & ~done_s & ~dis_s;
  wire drive_low = en_stat & (show_chg | pulse_on);
  assign stat_o = 1'b0;
  assign int_o = 1'b0;
  assign stat_oe = drive_low;
  assign int_oe = drive_low;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire aw_ok = aw_held | s_axi_awvalid;
  wire w_ok = w_held | s_axi_wvalid;
  wire wr_go = aw_ok & w_ok & ~s_axi_bvalid;
  wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
  wire rd_stat = rd_go & (s_axi_araddr == `CSIS_OFF_IRQ_STAT);

  function [31:0] csis_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      csis_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (st[i])
          csis_merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  function wr_hit;
    input [7:0] a;
    begin
      wr_hit = (a == `CSIS_OFF_CTRL) | (a == `CSIS_OFF_IRQ_MASK);
    end
  endfunction

  // Status word built field by field so the layout lives in the header only
  reg [31:0] status_word;
  always @*
  begin
    status_word = 32'h0000_0000;
    status_word[`CSIS_ST_HIZ] = dis_s;
    status_word[`CSIS_ST_CHARGING] = show_chg;
    status_word[`CSIS_ST_TS_FAULT] = ts_fault;
    status_word[`CSIS_ST_TS_OFF] = tsoff_s;
    status_word[`CSIS_ST_LIM_MSB:`CSIS_ST_LIM_LSB] = usb_limit;
    status_word[`CSIS_ST_FAULT] = pulse_on;
  end
  wire [31:0] mask_merged = csis_merge({29'h0, irq_mask}, wd, ws);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl <= `CSIS_CTRL_RESET;
      irq_mask <= {`CSIS_IRQ_W{1'b0}};
    end
    else
    begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit(wa) ? 2'h0 : 2'h2;
        if (wa == `CSIS_OFF_CTRL)
          ctrl <= csis_merge(ctrl, wd, ws) & 32'h0000_0003;
        if (wa == `CSIS_OFF_IRQ_MASK)
          irq_mask <= mask_merged[`CSIS_IRQ_W-1:0];
      end
      else
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
      end
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `CSIS_OFF_CTRL: s_axi_rdata <= ctrl;
        `CSIS_OFF_STATUS: s_axi_rdata <= status_word;
        `CSIS_OFF_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat};
        `CSIS_OFF_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------
  // Interrupt status, cleared by read; new events win over the clear
  // ----------------------------------------
  wire [`CSIS_IRQ_W-1:0] irq_evt = {done_s & ~done_d, ts_fault & ~tsf_d, flt_s & ~flt_d};
  always @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat <= {`CSIS_IRQ_W{1'b0}};
    else
      irq_stat <= (rd_stat ? {`CSIS_IRQ_W{1'b0}} : irq_stat) | irq_evt;
  end
  assign irq = |(irq_stat & irq_mask);
endmodule

/* File: logic/csis_regs.vh */
/*
  Register offsets, field positions, reset values and timing counts for the
  charger status and input-select block. Assumes a 125 MHz aclk and an
  AXI4-Lite register bus with 32-bit data.
*/
`ifndef CSIS_REGS_VH
`define CSIS_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CSIS_OFF_CTRL 8'h00
`define CSIS_OFF_STATUS 8'h04
`define CSIS_OFF_IRQ_STAT 8'h08
`define CSIS_OFF_IRQ_MASK 8'h0C

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CSIS_CTRL_EN_STAT 0
`define CSIS_CTRL_VARIANT_500 1
`define CSIS_CTRL_RESET 32'h0000_0001

// ----------------------------------------
// Status fields
// ----------------------------------------
`define CSIS_ST_HIZ 0
`define CSIS_ST_CHARGING 1
`define CSIS_ST_TS_FAULT 2
`define CSIS_ST_TS_OFF 3
`define CSIS_ST_LIM_LSB 4
`define CSIS_ST_LIM_MSB 5
`define CSIS_ST_FAULT 6

// ----------------------------------------
// USB input limit codes
// ----------------------------------------
`define CSIS_LIM_100 2'h0
`define CSIS_LIM_500 2'h1
`define CSIS_LIM_1500 2'h2

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define CSIS_IRQ_FAULT 0
`define CSIS_IRQ_TS 1
`define CSIS_IRQ_DONE 2
`define CSIS_IRQ_W 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CSIS_CLK_MHZ 125
`define CSIS_PULSE_US 128
`define CSIS_PULSE_CYC (`CSIS_PULSE_US * `CSIS_CLK_MHZ)

`endif

/* File: logic/csis_sync.v */
/*
  Two-flip-flop synchroniser for a bundle of level inputs.
  Assumes inputs are asynchronous pins; output lags by two edges.
*/
`timescale 1ns/1ns
module csis_sync #(
  parameter W = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] stage1;
  reg [W-1:0] stage2;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
    end
    else
    begin
      stage1 <= d;
      stage2 <= stage1;
    end
  end

  assign q = stage2;
endmodule

/* File: sim/csis_checker.sv */
/* Pin and register-bus assertions for csis_top.
   Assumes bind to csis_top; inputs are its ports. */
`timescale 1ns/1ns
module csis_checker (
  input wire aclk,
  input wire aresetn,
  input wire hw_disable_in,
  input wire thermistor_sense_at_gate_drive_supply,
  input wire usb_start,
  input wire hiz_mode,
  input wire [1:0] usb_limit,
  input wire lowest_usb_limit_mode,
  input wire adapter_limit_hold,
  input wire ts_monitor_en,
  input wire stat_o,
  input wire stat_oe,
  input wire int_o,
  input wire int_oe,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid
);
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Synchroniser is two flops deep, so pins show after two edges
  hiz_follow_a: assert property (
    $past(aresetn) && $past(aresetn, 2) |-> hiz_mode == $past(hw_disable_in, 2))
    else $error("hiz mode does not follow disable pin");
  ts_monitor_a: assert property (
    $past(aresetn) && $past(aresetn, 2)
    |-> ts_monitor_en == !$past(thermistor_sense_at_gate_drive_supply, 2))
    else $error("thermistor monitor enable wrong");
  lowest_mode_a: assert property (
    lowest_usb_limit_mode == (usb_limit == 2'h0))
    else $error("lowest usb mode flag wrong");
  adapter_path_a: assert property (
    adapter_limit_hold)
    else $error("adapter path disturbed");
  pins_alike_a: assert property (
    stat_oe == int_oe && !stat_o && !int_o)
    else $error("status pins differ");
  limit_cause_a: assert property (
    usb_limit != $past(usb_limit)
    |-> $past(usb_start, 3) || $past(usb_start, 4) || $past(usb_start, 5))
    else $error("usb limit changed without a start");
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule
bind csis_top csis_checker u_chk (.*);

/* File: sim/csis_host_pins.sv */
/* Host side of the two open-drain status lines.
   Assumes oe high means the block pulls the line low. */
`timescale 1ns/1ns
module csis_host_pins (
  input wire stat_o,
  input wire stat_oe,
  input wire int_o,
  input wire int_oe,
  output wire stat_pin,
  output wire int_pin
);
  // ----------------
  // Pull-ups
  // ----------------
  assign stat_pin = stat_oe ? stat_o : 1'h1;
  assign int_pin = int_oe ? int_o : 1'h1;
endmodule

/* File: sim/charger_status_input_select_tb.sv */
/* Self-checking bench for csis_top with host pull-ups.
   Assumes a short fault pulse count for run time. */
`timescale 1ns/1ns
module charger_status_input_select_tb;
  // ----------------
  // Setup
  // ----------------
  localparam P = 8;
  logic aclk = '0, aresetn = '0, hw_disable_in = '0, source_select = '1, has_dpdm = '0;
  logic usb_start = '0, dpdm_short = '0, charge_active = '0, charge_done = '0, fault_in = '0;
  logic ts_fault_in = '0, thermistor_sense_at_gate_drive_supply = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] rs;
  wire hiz_mode, lowest_usb_limit_mode, adapter_limit_hold, ts_monitor_en, stat_o, stat_oe;
  wire int_o, int_oe, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, stat_pin, int_pin;
  wire [1:0] usb_limit, s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int fail_count = 0, check_count = 0;
  csis_top #(.PULSE_CYC(P)) u_dut (.*);
  csis_host_pins u_host (.*);
  always #4 aclk = ~aclk;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bench acts at the rising edge; reads there see values settled before it
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    logic tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
      tb = s_axi_bvalid;
    end while (!tb);
    rs = s_axi_bresp;
    s_axi_bready <= '0;
  endtask
  task rd(input [7:0] a);
    logic t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= '0;
      t = s_axi_rvalid;
    end while (!t);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= '0;
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task t_regs;
    rd(8'h00);
    chk("ctrl", rv, 32'h1);
    rd(8'h0C);
    chk("mask", rv, 32'h0);
    rd(8'h10);
    chk("rresp", rs, 2'h2);
    wr(8'h10, 32'hFF);
    chk("bresp", rs, 2'h2);
  endtask
  task t_cd;
    charge_active <= '1;
    tick(4);
    chk("stat", stat_pin, 1'h0);
    chk("int", int_pin, 1'h0);
    hw_disable_in <= '1;
    tick(4);
    chk("hiz", hiz_mode, 1'h1);
    chk("stat", stat_pin, 1'h1);
    hw_disable_in <= '0;
    charge_done <= '1;
    tick(4);
    chk("hiz", hiz_mode, 1'h0);
    chk("int", int_pin, 1'h1);
    charge_active <= '0;
    charge_done <= '0;
    rd(8'h08);
  endtask
  task t_lim;
    // Bits: detect, short, source, variant, expected code
    logic [5:0] c [5] = '{6'h3A, 6'h20, 6'h12, 6'h08, 6'h0D};
    foreach (c[i])
    begin
      wr(8'h00, {30'h0, c[i][2], 1'h1});
      {has_dpdm, dpdm_short, source_select} <= c[i][5:3];
      tick(3);
      usb_start <= '1;
      tick(4);
      usb_start <= '0;
      tick(4);
      chk("limit", usb_limit, c[i][1:0]);
      chk("lowest", lowest_usb_limit_mode, c[i][1:0] == 2'h0);
      chk("adapter", adapter_limit_hold, 1'h1);
    end
  endtask
  task t_fault;
    int n;
    wr(8'h0C, 32'h7);
    chk("bresp", rs, 2'h0);
    rd(8'h0C);
    chk("mask", rv, 32'h7);
    fault_in <= '1;
    n = 0;
    while (!stat_oe && n < 20)
    begin
      tick(1);
      n++;
    end
    n = 0;
    while (stat_oe)
    begin
      tick(1);
      n++;
    end
    chk("pulse", n, P);
    chk("irq", irq, 1'h1);
    rd(8'h08);
    chk("irqstat", rv[0], 1'h1);
    tick(1);
    chk("irq", irq, 1'h0);
    fault_in <= '0;
    wr(8'h0C, 32'h0);
    fault_in <= '1;
    tick(4);
    chk("irq", irq, 1'h0);
    rd(8'h08);
    chk("irqstat", rv[0], 1'h1);
    fault_in <= '0;
    tick(P + 4);
  endtask
  task t_ts;
    ts_fault_in <= '1;
    tick(5);
    chk("tspulse", stat_oe, 1'h1);
    rd(8'h04);
    chk("tsfault", rv[2], 1'h1);
    ts_fault_in <= '0;
    thermistor_sense_at_gate_drive_supply <= '1;
    tick(P + 4);
    chk("tsmon", ts_monitor_en, 1'h0);
    ts_fault_in <= '1;
    tick(5);
    chk("tsquiet", stat_oe, 1'h0);
    ts_fault_in <= '0;
    thermistor_sense_at_gate_drive_supply <= '0;
  endtask
  task t_en;
    wr(8'h00, 32'h0);
    charge_active <= '1;
    fault_in <= '1;
    tick(5);
    chk("stat", stat_pin, 1'h1);
    chk("int", int_pin, 1'h1);
    wr(8'h00, 32'h1);
    tick(2);
    chk("stat", stat_pin, 1'h0);
    charge_active <= '0;
    fault_in <= '0;
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Pins are driven from time zero, never left floating
  initial
  begin
    tick(2);
    aresetn <= '1;
    t_regs;
    t_cd;
    t_lim;
    t_fault;
    t_ts;
    t_en;
    results;
  end
  initial
  begin
    #100000;
    fail_count++;
    results;
  end
endmodule
